// file: shared/seq_pkg.sv
// Purpose: Constants shared by the dual-rail sleep sequencer
// Assumes: 100 MHz ref_clk
// Notes: Long counts are also top-level parameters
package seq_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned SS_INTERVAL_US = 8200; // Soft-start interval
   localparam int unsigned SS_CYCLES = SS_INTERVAL_US * CLK_MHZ;
   localparam int unsigned S3_DELAY_US = 60; // S0 to S3 delay
   localparam int unsigned S3_DELAY_CYCLES = S3_DELAY_US * CLK_MHZ;
   localparam int unsigned DEGLITCH_NS = 200; // Sleep input filter
   localparam int unsigned DEGLITCH_CYCLES = (DEGLITCH_NS + 9) / 10;
   localparam int unsigned WAKE_SS_COUNT = 3; // Soft-starts before wake
   localparam int unsigned UV_RETRIES = 3; // Retries before latch-off
   localparam int unsigned CNT_W = 24;
   localparam int unsigned FILT_W = 8;
   typedef enum logic [1:0] {SEL_ACTIVE, SEL_SHALLOW, SEL_DEEP} sel_t;
   typedef enum logic [2:0] {
      ST_POR_WAIT, ST_RAMP, ST_SLEEP, ST_UV_OFF, ST_LATCHED, ST_WAKE_WAIT,
      ST_AWAKE
   } seq_state_t;
endpackage : seq_pkg

// file: src/input_filter.sv
// Purpose: Two-flop synchroniser plus stability filter for one input
// Assumes: Input is asynchronous to ref_clk
// Notes: Output changes only after the level holds for the full count
`timescale 1ns/1ns
`default_nettype none
module input_filter
   import seq_pkg::*;
#(
   parameter logic [FILT_W-1:0] COUNT = FILT_W'(DEGLITCH_CYCLES)
)(
   input wire logic ref_clk, // Clock
   input wire logic reset, // Sync reset, high
   input wire logic clk_en, // Freezes state when low
   input wire logic raw_in, // Asynchronous pin
   output logic filt_q // Filtered level
);
   logic sync1_q;
   logic sync2_q;
   logic [FILT_W-1:0] cnt_q;

   // Synchroniser; first flop feeds only the second
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end
      else if (clk_en)
      begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Stability counter rejects short spurious pulses
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cnt_q <= '0;
         filt_q <= 1'b1;
      end
      else if (clk_en)
      begin
         if (sync2_q == filt_q)
            cnt_q <= '0;
         else if (cnt_q >= COUNT - FILT_W'(1))
         begin
            cnt_q <= '0;
            filt_q <= sync2_q;
         end
         else
            cnt_q <= cnt_q + FILT_W'(1);
      end
   end
endmodule : input_filter
`default_nettype wire

// file: src/acpi_dual_rail_sequencer.sv
// Purpose: Digital sequencing of a dual-rail ACPI power controller
// Assumes: reset is the supply POR; rail_12v_ok and aux_rail_sense from
//    comparators, asynchronous to ref_clk
// Notes: Analog drive is modelled as enables
// Summary of operation
// - Both high active, deep high shallow low S3, both low S4/S5.
// - Deep low with shallow high keeps the previous selection.
// - S4/S5 never goes straight to S3.
// - Standby PFET gate on in S3 sleep.
// - Variant option keeps PFET gate on in S4/S5 too.
// - S0 to S3 waits 60 us; S0 to S4/S5 is immediate.
// - Sleep inputs are deglitched.
// - Wait one soft-start interval after supply POR release.
// - Digital soft-start ramp of 3.3V; at end PFET gate fully low, except in S4/S5 without the variant option.
// - Option variant sinks soft-start current for one period first.
// - No S0 entry until the 12V rail POR is satisfied.
// - Three soft-starts after 12V POR: release, PFET off, LDO standby.
// - Gate-release output only pulls low or floats.
// - Undervoltage watch only in sleep and after initial ramp.
// - Undervoltage is the comparator trip below 2.475V, 25% under.
// - Undervoltage disables LDO, retries after one soft-start interval.
// - Fourth undervoltage after 3 retries latches off until POR.
`timescale 1ns/1ns
`default_nettype none
module acpi_dual_rail_sequencer
   import seq_pkg::*;
#(
   parameter bit KEEP_5V_IN_DEEP = 1'b0, // Variant option
   parameter logic [CNT_W-1:0] SS_COUNT = CNT_W'(SS_CYCLES),
   parameter logic [CNT_W-1:0] S3_COUNT = CNT_W'(S3_DELAY_CYCLES)
)(
   input wire logic ref_clk, // 100 MHz clock
   input wire logic reset, // Supply POR, sync, high
   input wire logic clk_en, // Freezes all state when low
   input wire logic sleep_shallow_n, // Shallow sleep pin, low active
   input wire logic sleep_deep_n, // Deep sleep pin, low active
   input wire logic rail_12v_ok, // 12V rail above POR level
   input wire logic aux_rail_sense, // High when 3.3V below 2.475V
   output logic nfet_gate_release_o, // Always low when driven
   output logic nfet_gate_release_oe, // High while pulling low
   output logic standby_pfet_gate, // High means gate pulled high (off)
   output logic pfet_ss_sink, // Soft-start current sink on
   output logic ldo_enable, // 3.3V standby regulator on
   output logic ldo_soft_start, // Regulator ramp in progress
   output logic ldo_latched_off // Latch-off after repeated faults
);
   logic shallow_f;
   logic deep_f;
   logic v12_s1_q;
   logic v12_s2_q;
   logic uv_s1_q;
   logic uv_s2_q;
   sel_t sel_q;
   sel_t req;
   logic req_valid;
   seq_state_t state_q;
   logic [CNT_W-1:0] tmr_q;
   logic [CNT_W-1:0] dly_q;
   logic [1:0] wake_cnt_q;
   logic [1:0] retry_q;
   logic ramp_done_q;

   // True once a counter has reached its terminal count
   function automatic logic at_end(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] term);
      at_end = (cnt >= term - CNT_W'(1));
   endfunction : at_end

   input_filter u_filt_shallow (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .raw_in(sleep_shallow_n),
      .filt_q(shallow_f)
   );

   input_filter u_filt_deep (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .raw_in(sleep_deep_n),
      .filt_q(deep_f)
   );

   // Comparator levels cross into ref_clk through two flops
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         v12_s1_q <= 1'b0;
         v12_s2_q <= 1'b0;
         uv_s1_q <= 1'b0;
         uv_s2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         v12_s1_q <= rail_12v_ok;
         v12_s2_q <= v12_s1_q;
         uv_s1_q <= aux_rail_sense;
         uv_s2_q <= uv_s1_q;
      end
   end

   // Pin decode; the sleep pins follow the controller's requests
   always_comb
   begin
      req = sel_q;
      req_valid = 1'b1;
      case ({deep_f, shallow_f})
         2'b11: req = SEL_ACTIVE;
         2'b10: req = SEL_SHALLOW;
         2'b00: req = SEL_DEEP;
         default: req_valid = 1'b0;
      endcase
   end

   // Selected state; S0 to S3 goes through the delay counter
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sel_q <= SEL_DEEP;
         dly_q <= '0;
      end
      else if (clk_en)
      begin
         dly_q <= '0;
         if (!req_valid)
            sel_q <= sel_q;
         else if (sel_q == SEL_DEEP && req == SEL_SHALLOW)
            sel_q <= SEL_DEEP;
         else if (sel_q == SEL_ACTIVE && req == SEL_SHALLOW)
         begin
            // Short excursions toward S3 restart the wait
            if (at_end(dly_q, S3_COUNT))
               sel_q <= SEL_SHALLOW;
            else
               dly_q <= dly_q + CNT_W'(1);
         end
         else
            sel_q <= req;
      end
   end

   // Sequencing state machine with shared interval timer
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q <= ST_POR_WAIT;
         tmr_q <= '0;
         wake_cnt_q <= '0;
         retry_q <= '0;
         ramp_done_q <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state_q)
            ST_POR_WAIT:
            begin
               if (at_end(tmr_q, SS_COUNT))
               begin
                  tmr_q <= '0;
                  state_q <= ST_RAMP;
               end
               else
                  tmr_q <= tmr_q + CNT_W'(1);
            end
            ST_RAMP:
            begin
               if (at_end(tmr_q, SS_COUNT))
               begin
                  tmr_q <= '0;
                  ramp_done_q <= 1'b1;
                  state_q <= ST_SLEEP;
               end
               else
                  tmr_q <= tmr_q + CNT_W'(1);
            end
            ST_SLEEP:
            begin
               tmr_q <= '0;
               wake_cnt_q <= '0;
               if (sel_q != SEL_ACTIVE && ramp_done_q && uv_s2_q)
               begin
                  if (retry_q == 2'(UV_RETRIES))
                     state_q <= ST_LATCHED;
                  else
                     state_q <= ST_UV_OFF;
               end
               else if (sel_q == SEL_ACTIVE && v12_s2_q)
                  state_q <= ST_WAKE_WAIT;
            end
            ST_UV_OFF:
            begin
               if (at_end(tmr_q, SS_COUNT))
               begin
                  tmr_q <= '0;
                  retry_q <= retry_q + 2'd1;
                  state_q <= ST_RAMP;
               end
               else
                  tmr_q <= tmr_q + CNT_W'(1);
            end
            ST_LATCHED:
               state_q <= ST_LATCHED;
            ST_WAKE_WAIT:
            begin
               if (sel_q != SEL_ACTIVE || !v12_s2_q)
               begin
                  tmr_q <= '0;
                  state_q <= ST_SLEEP;
               end
               else if (at_end(tmr_q, SS_COUNT))
               begin
                  tmr_q <= '0;
                  if (wake_cnt_q == 2'(WAKE_SS_COUNT - 1))
                     state_q <= ST_AWAKE;
                  else
                     wake_cnt_q <= wake_cnt_q + 2'd1;
               end
               else
                  tmr_q <= tmr_q + CNT_W'(1);
            end
            ST_AWAKE:
            begin
               // Sleep entry brings the regulator back without a new ramp
               if (sel_q != SEL_ACTIVE || !v12_s2_q)
                  state_q <= ST_SLEEP;
            end
            default:
               state_q <= ST_POR_WAIT;
         endcase
      end
   end

   // Output drive, registered so every pin comes from a flop
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         nfet_gate_release_o <= 1'b0;
         nfet_gate_release_oe <= 1'b1;
         standby_pfet_gate <= 1'b1;
         pfet_ss_sink <= 1'b0;
         ldo_enable <= 1'b0;
         ldo_soft_start <= 1'b0;
         ldo_latched_off <= 1'b0;
      end
      else if (clk_en)
      begin
         nfet_gate_release_o <= 1'b0;
         nfet_gate_release_oe <= (state_q != ST_AWAKE);
         ldo_enable <= (state_q == ST_RAMP || state_q == ST_SLEEP ||
                        state_q == ST_WAKE_WAIT);
         ldo_soft_start <= (state_q == ST_RAMP);
         ldo_latched_off <= (state_q == ST_LATCHED);
         pfet_ss_sink <= KEEP_5V_IN_DEEP && state_q == ST_RAMP &&
                         !ramp_done_q;
         if (state_q == ST_AWAKE)
            standby_pfet_gate <= 1'b1;
         else if (state_q == ST_POR_WAIT || state_q == ST_RAMP && !ramp_done_q)
            standby_pfet_gate <= 1'b1;
         else if (sel_q == SEL_SHALLOW)
            standby_pfet_gate <= 1'b0;
         else if (sel_q == SEL_DEEP)
            standby_pfet_gate <= !KEEP_5V_IN_DEEP;
         else
            standby_pfet_gate <= 1'b0;
      end
   end
endmodule : acpi_dual_rail_sequencer
`default_nettype wire

// file: testbench/sleep_host.sv
// Purpose: Power-management controller model driving the sleep pins
// Assumes: Requests come from the bench as levels
// Notes: Pins move on the clock edge by non-blocking update, race free
`timescale 1ns/1ns
`default_nettype none
module sleep_host (
   input wire logic ref_clk, // Clock
   input wire logic host_sleep_shallow_n, // Shallow request, low active
   input wire logic host_sleep_deep_n, // Deep request, low active
   output logic sleep_shallow_n, // Shallow pin
   output logic sleep_deep_n // Deep pin
);
   // Each pin follows its own request, high while awake
   always @(posedge ref_clk)
   begin
      sleep_shallow_n <= host_sleep_shallow_n;
      sleep_deep_n <= host_sleep_deep_n;
   end
endmodule : sleep_host
`default_nettype wire

// file: testbench/acpi_dual_rail_sequencer_checker.sv
// Purpose: Port-level assertions for the sleep sequencer
// Assumes: One clock domain, reset active high
// Notes: Bound to every instance of the sequencer
`timescale 1ns/1ns
`default_nettype none
module acpi_dual_rail_sequencer_checker
   import seq_pkg::*;
#(
   parameter logic [CNT_W-1:0] SS_COUNT = CNT_W'(SS_CYCLES),
   parameter logic [CNT_W-1:0] S3_COUNT = CNT_W'(S3_DELAY_CYCLES)
)(
   input wire logic ref_clk, // Clock
   input wire logic reset, // Reset
   input wire logic rail_12v_ok, // 12V good
   input wire logic nfet_gate_release_o, // Release data
   input wire logic nfet_gate_release_oe, // Release enable
   input wire logic standby_pfet_gate, // PFET gate
   input wire logic pfet_ss_sink, // Sink on
   input wire logic ldo_enable, // Regulator on
   input wire logic ldo_soft_start, // Ramp running
   input wire logic ldo_latched_off // Latch-off
);
   // All checks share the one clock and reset
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   a_release_only_low:
      assert property (!nfet_gate_release_o) else $error("release high");
   a_awake_outputs:
      assert property (!nfet_gate_release_oe |-> standby_pfet_gate &&
         !ldo_enable) else $error("awake outputs wrong");
   a_wake_needs_12v:
      assert property ($fell(nfet_gate_release_oe) |-> $past(rail_12v_ok, 10))
      else $error("woke without 12V");
   a_pfet_only_sleep:
      assert property (!standby_pfet_gate |-> nfet_gate_release_oe)
      else $error("pfet on while awake");
   a_latch_sticky:
      assert property (ldo_latched_off |=> ldo_latched_off)
      else $error("latch cleared");
   a_latch_ldo_off:
      assert property (ldo_latched_off |-> !ldo_enable && !ldo_soft_start)
      else $error("latched but enabled");
   a_ramp_enabled:
      assert property (ldo_soft_start |-> ldo_enable) else $error("ramp off");
   a_sink_in_ramp:
      assert property (pfet_ss_sink |-> ldo_soft_start)
      else $error("sink outside ramp");
   a_por_wait_off:
      assert property ($fell(reset) |-> !ldo_enable [*8])
      else $error("regulator on too early");
   a_uv_off_time:
      assert property ($fell(ldo_enable) && nfet_gate_release_oe |=>
         !ldo_enable [*8]) else $error("retry too soon");
   c_wake: cover property ($fell(nfet_gate_release_oe));
   c_latch: cover property ($rose(ldo_latched_off));
   c_sink: cover property ($rose(pfet_ss_sink));
endmodule : acpi_dual_rail_sequencer_checker
bind acpi_dual_rail_sequencer acpi_dual_rail_sequencer_checker #(
   .SS_COUNT(SS_COUNT), .S3_COUNT(S3_COUNT)) u_chk (.ref_clk(ref_clk),
   .reset(reset), .rail_12v_ok(rail_12v_ok),
   .nfet_gate_release_o(nfet_gate_release_o),
   .nfet_gate_release_oe(nfet_gate_release_oe),
   .standby_pfet_gate(standby_pfet_gate), .pfet_ss_sink(pfet_ss_sink),
   .ldo_enable(ldo_enable), .ldo_soft_start(ldo_soft_start),
   .ldo_latched_off(ldo_latched_off));
`default_nettype wire

// file: testbench/acpi_dual_rail_sequencer_tb.sv
// Purpose: Self-checking bench for the sleep sequencer
// Assumes: Short counts: soft-start 50, shallow delay 10
// Notes: Second instance runs the keep-5V variant on the same inputs
`timescale 1ns/1ns
`default_nettype none
module acpi_dual_rail_sequencer_tb;
   import seq_pkg::*;
   localparam int SSN = 50;
   logic ref_clk, reset, rail_12v_ok, aux_rail_sense;
   logic host_sleep_shallow_n, host_sleep_deep_n, pin_sh_n, pin_dp_n;
   logic rel_o, rel_oe, pgate, sink, ldo_en, ldo_ss, latched;
   logic a_pgate, a_sink, a_o, a_oe, a_ldo, a_ss, a_lat, clk_en;
   int errors, checks, cycles;
   sleep_host u_host (.ref_clk(ref_clk),
      .host_sleep_shallow_n(host_sleep_shallow_n),
      .host_sleep_deep_n(host_sleep_deep_n),
      .sleep_shallow_n(pin_sh_n), .sleep_deep_n(pin_dp_n));
   acpi_dual_rail_sequencer #(.KEEP_5V_IN_DEEP(1'b0), .SS_COUNT(24'h000032),
      .S3_COUNT(24'h00000A)) u_dut (.ref_clk(ref_clk), .reset(reset),
      .clk_en(clk_en), .sleep_shallow_n(pin_sh_n), .sleep_deep_n(pin_dp_n),
      .rail_12v_ok(rail_12v_ok), .aux_rail_sense(aux_rail_sense),
      .nfet_gate_release_o(rel_o), .nfet_gate_release_oe(rel_oe),
      .standby_pfet_gate(pgate), .pfet_ss_sink(sink), .ldo_enable(ldo_en),
      .ldo_soft_start(ldo_ss), .ldo_latched_off(latched));
   acpi_dual_rail_sequencer #(.KEEP_5V_IN_DEEP(1'b1), .SS_COUNT(24'h000032),
      .S3_COUNT(24'h00000A)) u_alt (.ref_clk(ref_clk), .reset(reset),
      .clk_en(clk_en), .sleep_shallow_n(pin_sh_n), .sleep_deep_n(pin_dp_n),
      .rail_12v_ok(rail_12v_ok), .aux_rail_sense(aux_rail_sense),
      .nfet_gate_release_o(a_o), .nfet_gate_release_oe(a_oe),
      .standby_pfet_gate(a_pgate), .pfet_ss_sink(a_sink), .ldo_enable(a_ldo),
      .ldo_soft_start(a_ss), .ldo_latched_off(a_lat));
   // Free-running 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Hang guard; the whole run needs under 2000 cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         give_verdict();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic chk(input string what, input logic seen, input logic exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict;
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // Power-up into deep sleep; a dip during the first ramp is ignored
   task automatic t_power_up;
      cyc(SSN - 5);
      chk("ldo_en_wait", ldo_en, 1'b0);
      // Freeze across the end of the wait; the timer must not advance
      clk_en = 1'b0;
      cyc(20);
      chk("freeze_wait", ldo_en, 1'b0);
      clk_en = 1'b1;
      aux_rail_sense = 1'b1;
      cyc(15);
      aux_rail_sense = 1'b0;
      chk("ldo_ramp", ldo_ss, 1'b1);
      chk("sink_alt", a_sink, 1'b1);
      chk("ramp_alt", a_ss, 1'b1);
      chk("sink_base", sink, 1'b0);
      cyc(SSN + 10);
      chk("ramp_done", ldo_ss, 1'b0);
      chk("pgate_deep", pgate, 1'b1);
      chk("pgate_deep_alt", a_pgate, 1'b0);
      chk("sink_done", a_sink, 1'b0);
   endtask : t_power_up
   // Wake held off by 12V, then three intervals; dips and glitches ignored
   task automatic t_wake;
      host_sleep_shallow_n = 1'b1;
      host_sleep_deep_n = 1'b1;
      cyc(3 * SSN + 40);
      chk("no_12v", rel_oe, 1'b1);
      rail_12v_ok = 1'b1;
      cyc(3 * SSN - 10);
      chk("wake_early", rel_oe, 1'b1);
      cyc(30);
      chk("wake_oe", rel_oe, 1'b0);
      chk("wake_pgate", pgate, 1'b1);
      chk("wake_ldo", ldo_en, 1'b0);
      chk("wake_o", rel_o, 1'b0);
      chk("wake_oe_alt", a_oe, 1'b0);
      chk("wake_o_alt", a_o, 1'b0);
      aux_rail_sense = 1'b1;
      host_sleep_shallow_n = 1'b0;
      cyc(5);
      aux_rail_sense = 1'b0;
      host_sleep_shallow_n = 1'b1;
      cyc(60);
      chk("glitch", rel_oe, 1'b0);
   endtask : t_wake
   // Awake to shallow with delay, disallowed pair, deep, refused shallow
   task automatic t_sleep_moves;
      host_sleep_shallow_n = 1'b0;
      cyc(28);
      chk("s3_delay", rel_oe, 1'b0);
      cyc(30);
      chk("s3_oe", rel_oe, 1'b1);
      chk("s3_pgate", pgate, 1'b0);
      host_sleep_shallow_n = 1'b1;
      host_sleep_deep_n = 1'b0;
      cyc(60);
      chk("hold_prev", pgate, 1'b0);
      host_sleep_shallow_n = 1'b0;
      cyc(40);
      chk("deep_pgate", pgate, 1'b1);
      chk("deep_alt", a_pgate, 1'b0);
      host_sleep_deep_n = 1'b1;
      cyc(60);
      chk("no_deep_s3", pgate, 1'b1);
      host_sleep_shallow_n = 1'b1;
      cyc(3 * SSN + 30);
      chk("rewake", rel_oe, 1'b0);
      host_sleep_shallow_n = 1'b0;
      host_sleep_deep_n = 1'b0;
      cyc(30);
      chk("deep_fast", rel_oe, 1'b1);
   endtask : t_sleep_moves
   // Three retries, then the fourth dip latches until a new reset
   task automatic t_undervolt;
      for (int i = 0; i < 4; i++)
      begin
         aux_rail_sense = 1'b1;
         cyc(5);
         aux_rail_sense = 1'b0;
         cyc(5);
         chk("uv_off", ldo_en, 1'b0);
         chk("uv_latch", latched, i == 3);
         chk("uv_off_alt", a_ldo, 1'b0);
         chk("uv_latch_alt", a_lat, i == 3);
         cyc(SSN + 5);
         chk("uv_retry", ldo_en, i < 3);
         cyc(SSN);
      end
      reset = 1'b1;
      cyc(4);
      reset = 1'b0;
      cyc(2);
      chk("latch_cleared", latched, 1'b0);
   endtask : t_undervolt
   // Main sequence
   initial
   begin
      reset = 1'b1;
      clk_en = 1'b1;
      rail_12v_ok = 1'b0;
      aux_rail_sense = 1'b0;
      host_sleep_shallow_n = 1'b0;
      host_sleep_deep_n = 1'b0;
      errors = 0;
      checks = 0;
      cycles = 0;
      cyc(4);
      reset = 1'b0;
      t_power_up();
      t_wake();
      t_sleep_moves();
      t_undervolt();
      give_verdict();
   end
endmodule : acpi_dual_rail_sequencer_tb
`default_nettype wire
